/* emb_mult_tile.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_mult_tile (
  // clock and bus reset
  input wire logic clk,
  input wire logic rst,
  // tile controls shared by the input, sign and output registers
  input wire logic aclr,
  input wire logic ena,
  // operands from the fabric
  input wire emb_mult_pkg::operand_t opnd_a,
  input wire emb_mult_pkg::operand_t opnd_b,
  // product to the fabric
  output emb_mult_pkg::product_t result,
  // register port
  input wire logic [emb_mult_pkg::ADDR_W-1:0] addr,
  input wire logic [emb_mult_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [emb_mult_pkg::DATA_W-1:0] rdata
);
  import emb_mult_pkg::*;

  // ****************************************
  // functions
  // ****************************************
  // extend by one bit so one signed multiply covers all four sign cases
  function automatic logic [PROD_W-1:0] wide_mul(
    input logic [OP_W-1:0] a,
    input logic [OP_W-1:0] b,
    input logic sa,
    input logic sb
  );
    logic signed [OP_W:0] ea;
    logic signed [OP_W:0] eb;
    logic signed [2*OP_W+1:0] p;
    begin
      ea = {sa & a[OP_W-1], a};
      eb = {sb & b[OP_W-1], b};
      p = ea * eb;
      wide_mul = p[PROD_W-1:0];
    end
  endfunction

  function automatic logic [LANE_PROD_W-1:0] lane_mul(
    input logic [LANE_W-1:0] a,
    input logic [LANE_W-1:0] b,
    input logic sa,
    input logic sb
  );
    logic signed [LANE_W:0] ea;
    logic signed [LANE_W:0] eb;
    logic signed [2*LANE_W+1:0] p;
    begin
      ea = {sa & a[LANE_W-1], a};
      eb = {sb & b[LANE_W-1], b};
      p = ea * eb;
      lane_mul = p[LANE_PROD_W-1:0];
    end
  endfunction

  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] ofs
  );
    begin
      hit = (a == ofs);
    end
  endfunction

  // ****************************************
  // configuration register
  // ****************************************
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  wire ctrl_wr = wr & hit(addr, CTRL_OFS);

  assign next_ctrl = ctrl_wr ? wdata[CTRL_W-1:0] : ctrl;

  // config lives on the bus reset, not the tile clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  wire cfg_dual = ctrl[CTRL_DUAL];
  wire cfg_reg_a = ctrl[CTRL_REG_A];
  wire cfg_reg_b = ctrl[CTRL_REG_B];
  wire cfg_reg_sign = ctrl[CTRL_REG_SIGN];
  wire cfg_reg_out = ctrl[CTRL_REG_OUT];
  mode_t mode;

  // narrow lanes for 9-bit operands, wide for 10 to 18 bits
  assign mode = cfg_dual ? MODE_DUAL : MODE_WIDE;

  // ****************************************
  // sign selects
  // ****************************************
  // a sign select left unused reads as unsigned
  wire sa_in = opnd_a.sign & ctrl[CTRL_SIGN_A_USED];
  wire sb_in = opnd_b.sign & ctrl[CTRL_SIGN_B_USED];

  // ****************************************
  // input registers
  // ****************************************
  logic [OP_W-1:0] a_q;
  logic [OP_W-1:0] b_q;
  logic sa_q;
  logic sb_q;

  // one clock, one enable, one clear for every datapath register
  always_ff @(posedge clk or posedge aclr) begin
    if (aclr) begin
      a_q <= 18'h00000;
      b_q <= 18'h00000;
    end else if (rst) begin
      a_q <= 18'h00000;
      b_q <= 18'h00000;
    end else if (ena) begin
      a_q <= opnd_a.data;
      b_q <= opnd_b.data;
    end
  end

  // sign registers ride with the operand registers
  always_ff @(posedge clk or posedge aclr) begin
    if (aclr) begin
      sa_q <= 1'b0;
      sb_q <= 1'b0;
    end else if (rst) begin
      sa_q <= 1'b0;
      sb_q <= 1'b0;
    end else if (ena) begin
      sa_q <= sa_in;
      sb_q <= sb_in;
    end
  end

  // ****************************************
  // operand selection
  // ****************************************
  // each operand chooses register or direct path on its own; both sign selects share one choice
  wire [OP_W-1:0] a_mul = cfg_reg_a ? a_q : opnd_a.data;
  wire [OP_W-1:0] b_mul = cfg_reg_b ? b_q : opnd_b.data;
  wire sa_mul = cfg_reg_sign ? sa_q : sa_in;
  wire sb_mul = cfg_reg_sign ? sb_q : sb_in;

  // ****************************************
  // multiplier stage
  // ****************************************
  // one select per operand, both lanes share it; fabric keeps lanes alike
  logic [PROD_W-1:0] lane_prod;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_prod[g*LANE_PROD_W +: LANE_PROD_W] = lane_mul(
        a_mul[g*LANE_W +: LANE_W],
        b_mul[g*LANE_W +: LANE_W],
        sa_mul,
        sb_mul
      );
    end
  endgenerate

  wire [PROD_W-1:0] wide_prod = wide_mul(a_mul, b_mul, sa_mul, sb_mul);

  // two products in parallel or one, by mode
  wire [PROD_W-1:0] prod_comb = (mode == MODE_DUAL) ? lane_prod : wide_prod;
  wire signed_comb = sa_mul | sb_mul;

  // ****************************************
  // output registers
  // ****************************************
  logic [PROD_W-1:0] prod_q;
  logic signed_q;

  // two 18-bit sections in dual mode, one 36-bit in wide; same storage
  always_ff @(posedge clk or posedge aclr) begin
    if (aclr) begin
      prod_q <= 36'h000000000;
      signed_q <= 1'b0;
    end else if (rst) begin
      prod_q <= 36'h000000000;
      signed_q <= 1'b0;
    end else if (ena) begin
      prod_q <= prod_comb;
      signed_q <= signed_comb;
    end
  end

  // bypassed product is combinational: a register here would add latency
  assign result.value = cfg_reg_out ? prod_q : prod_comb;
  assign result.is_signed = cfg_reg_out ? signed_q : signed_comb;

  // ****************************************
  // read port
  // ****************************************
  wire [DATA_W-1:0] rd_ctrl = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
  wire [DATA_W-1:0] rd_lo = result.value[DATA_W-1:0];
  logic [DATA_W-1:0] rd_hi;
  logic [DATA_W-1:0] rd_opa;
  logic [DATA_W-1:0] rd_opb;
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_hi = 32'h00000000;
    rd_hi[HI_TOP_W-1:0] = result.value[PROD_W-1:DATA_W];
    rd_hi[HI_SIGNED] = result.is_signed;
    rd_hi[HI_DUAL] = cfg_dual;
  end

  always_comb begin
    rd_opa = 32'h00000000;
    rd_opa[OP_W-1:0] = a_mul;
    rd_opa[OPND_SIGN] = sa_mul;
    rd_opb = 32'h00000000;
    rd_opb[OP_W-1:0] = b_mul;
    rd_opb[OPND_SIGN] = sb_mul;
  end

  // unmapped offsets read as zero
  assign rd_mux = hit(addr, CTRL_OFS) ? rd_ctrl :
                  hit(addr, PROD_LO_OFS) ? rd_lo :
                  hit(addr, PROD_HI_OFS) ? rd_hi :
                  hit(addr, OPND_A_OFS) ? rd_opa :
                  hit(addr, OPND_B_OFS) ? rd_opb :
                  32'h00000000;

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

/* emb_mult_pkg.sv */
// How it works
// - one 18x18 or two 9x9 multipliers
// - one or two products, any width between
// - operands registered or direct, 9/18-bit sections
// - register-or-bypass chosen per operand, one choice shared by both sign selects
// - one clock, enable, clear for all datapath registers
// - sign select high means two's complement
// - product signed if either operand signed
// - one sign select per operand, shared lanes
// - sign selects may change every cycle
// - sign selects optionally registered with operands
// - full precision product for every signedness
// - unused sign selects mean unsigned
// - optional output register, 18/36-bit sections
// - wide mode for 10 to 18 bits
// - dual mode for up to 9 bits
package emb_mult_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int OP_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int PROD_W = 36;
  localparam int LANE_PROD_W = 18;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PROD_LO_OFS = 8'h04;
  localparam logic [7:0] PROD_HI_OFS = 8'h08;
  localparam logic [7:0] OPND_A_OFS = 8'h0C;
  localparam logic [7:0] OPND_B_OFS = 8'h10;

  // ctrl bits
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_REG_A = 1;
  localparam int CTRL_REG_B = 2;
  localparam int CTRL_REG_SIGN = 3;
  localparam int CTRL_REG_OUT = 4;
  localparam int CTRL_SIGN_A_USED = 5;
  localparam int CTRL_SIGN_B_USED = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // prod_hi layout
  localparam int HI_TOP_W = 4;
  localparam int HI_SIGNED = 8;
  localparam int HI_DUAL = 9;
  // operand readback layout
  localparam int OPND_SIGN = 18;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_WIDE = 2'b01,
    MODE_DUAL = 2'b10
  } mode_t;

  typedef struct packed {
    logic [17:0] data;
    logic sign;
  } operand_t;

  typedef struct packed {
    logic is_signed;
    logic [35:0] value;
  } product_t;

endpackage

/* emb_mult_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_mult_sva (
  // clock and controls
  input wire logic clk,
  input wire logic rst,
  input wire logic aclr,
  input wire logic ena,
  // datapath
  input wire emb_mult_pkg::operand_t opnd_a,
  input wire emb_mult_pkg::operand_t opnd_b,
  input wire emb_mult_pkg::product_t result,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata
);
  import emb_mult_pkg::*;
  // ****
  // ctrl shadow, kept from bus writes
  // ****
  logic [6:0] cs;
  logic signed [37:0] pw;
  logic signed [19:0] p0;
  wire logic ea = cs[5] & opnd_a.sign;
  wire logic eb = cs[6] & opnd_b.sign;
  assign pw = $signed({ea & opnd_a.data[17], opnd_a.data}) * $signed({eb & opnd_b.data[17], opnd_b.data});
  assign p0 = $signed({ea & opnd_a.data[8], opnd_a.data[8:0]}) * $signed({eb & opnd_b.data[8], opnd_b.data[8:0]});
  always_ff @(posedge clk) begin
    if (rst) cs <= CTRL_RESET;
    else if (wr && addr == CTRL_OFS) cs <= wdata[6:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wide_comb: assert property (cs[4:0] == 5'h00 |-> result.value == pw[35:0])
    else $error("wide product wrong");
  a_dual_lane: assert property (cs[4:0] == 5'h01 |-> result.value[17:0] == p0[17:0])
    else $error("low lane product wrong");
  a_sign_comb: assert property (cs[4:3] == 2'b00 |-> result.is_signed == (ea | eb))
    else $error("product sign wrong");
  a_sign_unused: assert property (cs[6:3] == 4'h0 |-> !result.is_signed)
    else $error("unused signs not unsigned");
  a_aclr_zero: assert property (aclr && cs[4] |-> result == '0)
    else $error("clear left output");
  a_hold_ena: assert property (cs[4] && !ena && !aclr ##1 cs[4] && !aclr |-> $stable(result))
    else $error("output moved with enable low");
  a_reg_lat: assert property (ena && !aclr && cs == 7'h10 ##1 !aclr && cs == 7'h10
    |-> result.value == $past(opnd_a.data) * $past(opnd_b.data))
    else $error("registered product wrong");
  a_rdata_lo: assert property (rd && addr == PROD_LO_OFS |=> rdata == 32'($past(result)))
    else $error("low product read wrong");
endmodule
`default_nettype wire

/* fabric_src.sv */
`timescale 1ns/1ps
`default_nettype none
module fabric_src (
  // clock and load request
  input wire logic clk,
  input wire logic load,
  // operand values
  input wire logic [17:0] a_in,
  input wire logic [17:0] b_in,
  input wire logic sa_in,
  input wire logic sb_in,
  // to the tile
  output var emb_mult_pkg::operand_t opnd_a,
  output var emb_mult_pkg::operand_t opnd_b
);
  import emb_mult_pkg::*;
  // ****
  // operand source
  // ****
  initial begin
    opnd_a = '0;
    opnd_b = '0;
  end
  // one sign per operand, so both lanes always agree
  always @(posedge clk) begin
    if (load) begin
      opnd_a <= '{a_in, sa_in};
      opnd_b <= '{b_in, sb_in};
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import emb_mult_pkg::*;
  logic clk = 0, rst = 1, aclr = 0, ena = 1, wr = 0, rd = 0, load = 0, sa = 0, sb = 0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [17:0] a = '0, b = '0;
  logic [36:0] ex;
  logic [6:0] cfg [4] = '{7'h00, 7'h60, 7'h01, 7'h61};
  operand_t opnd_a, opnd_b;
  product_t result;
  int n_mismatch = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  fabric_src partner (.clk(clk), .load(load), .a_in(a), .b_in(b), .sa_in(sa), .sb_in(sb),
    .opnd_a(opnd_a), .opnd_b(opnd_b));
  emb_mult_tile dut (.clk(clk), .rst(rst), .aclr(aclr), .ena(ena), .opnd_a(opnd_a), .opnd_b(opnd_b),
    .result(result), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  // ****
  // helpers
  // ****
  task automatic chk(string nm, logic [36:0] seen, logic [36:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, ad, d};
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_reg(logic [7:0] ad, logic [31:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, ad};
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", 37'(rdata), 37'(e));
  endtask
  task automatic op(logic [17:0] na, logic [17:0] nb, logic nsa, logic nsb);
    @(posedge clk);
    {load, a, b, sa, sb} <= {1'b1, na, nb, nsa, nsb};
    @(posedge clk);
    load <= 0;
  endtask
  // register bits ignored: expects settled operands and signs
  function automatic logic [36:0] mdl(logic [6:0] c, logic [17:0] x, logic [17:0] y, logic u, logic v);
    logic signed [37:0] pw;
    logic signed [19:0] p0, p1;
    u = u & c[5];
    v = v & c[6];
    pw = $signed({u & x[17], x}) * $signed({v & y[17], y});
    p0 = $signed({u & x[8], x[8:0]}) * $signed({v & y[8], y[8:0]});
    p1 = $signed({u & x[17], x[17:9]}) * $signed({v & y[17], y[17:9]});
    return {u | v, c[0] ? {p1[17:0], p0[17:0]} : pw[35:0]};
  endfunction
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    rd_reg(CTRL_OFS, 32'h0);
    foreach (cfg[i]) for (int s = 0; s < 4; s++) begin
      wr_reg(CTRL_OFS, {25'h0, cfg[i]});
      op(18'h20003, 18'h3FFFE, s[0], s[1]);
      ex = mdl(cfg[i], 18'h20003, 18'h3FFFE, s[0], s[1]);
      #1 chk("res", result, ex);
      rd_reg(PROD_LO_OFS, ex[31:0]);
      rd_reg(PROD_HI_OFS, {22'h0, cfg[i][0], ex[36], 4'h0, ex[35:32]});
    end
    wr_reg(PROD_LO_OFS, 32'h0);
    rd_reg(PROD_LO_OFS, ex[31:0]);
    for (int i = 0; i < 2; i++) begin
      wr_reg(CTRL_OFS, i ? 32'h7E : 32'h10);
      op(18'h1FFFF, 18'h3FFFF, 1, 1);
      ex = mdl(i ? 7'h7E : 7'h10, 18'h1FFFF, 18'h3FFFF, 1, 1);
      repeat (i + 1) @(posedge clk);
      #1 chk("pipe", result, ex);
      ena <= 0;
      op(18'h0, 18'h0, 0, 0);
      repeat (3) @(posedge clk);
      #1 chk("hold", result, ex);
      aclr = 1;
      #1 chk("clr", result, 37'h0);
      @(posedge clk);
      {aclr, ena} <= 2'b01;
    end
    wr_reg(CTRL_OFS, 32'h02);
    op(18'h3, 18'h5, 0, 0);
    @(posedge clk);
    ena <= 0;
    #1 chk("reg_a", result, 37'hF);
    op(18'h4, 18'h9, 0, 0);
    #1 chk("byp_b", result, 37'h1B);
    ena <= 1;
    wr_reg(CTRL_OFS, 32'h68);
    for (int s = 1; s >= 0; s--) begin
      op(18'h3FFFF, 18'h1, s[0], 0);
      #1 chk("sgn_lag", result, mdl(7'h68, 18'h3FFFF, 18'h1, !s[0], 0));
      @(posedge clk);
      #1 chk("sgn_now", result, mdl(7'h68, 18'h3FFFF, 18'h1, s[0], 0));
    end
    rd_reg(OPND_A_OFS, 32'h0003FFFF);
    rd_reg(OPND_B_OFS, 32'h00000001);
    wrap_up();
  end
endmodule
bind emb_mult_tile emb_mult_sva sva (.clk(clk), .rst(rst), .aclr(aclr), .ena(ena), .opnd_a(opnd_a),
  .opnd_b(opnd_b), .result(result), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
`default_nettype wire
